// file: hscg_pkg.sv
package hscg_pkg;
  // register byte offsets
  localparam logic [7:0] HSCG_OFF_GPT_CFG = 8'h8c;
  localparam logic [7:0] HSCG_OFF_GPT_CUR = 8'h90;
  localparam logic [7:0] HSCG_OFF_WORD_ORDER = 8'h98;
  localparam logic [7:0] HSCG_OFF_TICK = 8'h9c;
  localparam logic [7:0] HSCG_OFF_DROP = 8'ha0;
  localparam logic [7:0] HSCG_OFF_MAC_CMD = 8'ha4;
  localparam logic [7:0] HSCG_OFF_MAC_DATA = 8'ha8;
  localparam logic [7:0] HSCG_OFF_EVENT = 8'hb0;
  // field positions
  localparam int HSCG_CMD_PENDING_BIT = 31;
  localparam int HSCG_CMD_RNW_BIT = 30;
  localparam int HSCG_TMR_RUN_BIT = 29;
  localparam int HSCG_DROP_MID_BIT = 31;
  localparam int HSCG_HALF_SEL_BIT = 1;
  // reset and special values
  localparam logic [15:0] HSCG_TMR_ONES = 16'hffff;
  localparam logic [31:0] HSCG_SWAP_KEY = 32'hffffffff;
  localparam logic [31:0] HSCG_ZERO32 = 32'h00000000;
  localparam logic [15:0] HSCG_ZERO16 = 16'h0000;
  localparam logic [7:0] HSCG_ZERO8 = 8'h00;
  // tick timing: 25 MHz ticks from a 100 MHz clock
  localparam int HSCG_CLK_MHZ = 100;
  localparam int HSCG_TICK_MHZ = 25;
  localparam int HSCG_TICK_DIV = HSCG_CLK_MHZ / HSCG_TICK_MHZ;
  localparam int HSCG_TICK_CLEAR_NS = 160;
  localparam int HSCG_CLK_NS = 10;
  localparam int HSCG_TICK_CLEAR_CYC = HSCG_TICK_CLEAR_NS / HSCG_CLK_NS;
  localparam logic [1:0] HSCG_DIV_LAST = 2'(HSCG_TICK_DIV - 1);
  localparam logic [31:0] HSCG_ONE32 = 32'h00000001;
  localparam logic [15:0] HSCG_ONE16 = 16'h0001;
endpackage : hscg_pkg

// file: hscg_mac_if.sv
// carrier between the command sequencer and the mac-side port
interface hscg_mac_if;
  logic req;
  logic rnw;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic done;
  logic [31:0] rdata;
  modport seq (output req, output rnw, output addr, output wdata, input done, input rdata);
  modport port (input req, input rnw, input addr, input wdata, output done, output rdata);
endinterface : hscg_mac_if

// file: hscg_mac_seq.sv
// one-shot sequencer: holds a mac access open until the far side answers
module hscg_mac_seq
  import hscg_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic start,
  input wire logic rnw,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  output logic busy,
  output logic finish,
  output logic [31:0] rdata,
  hscg_mac_if.seq mac
);
  typedef enum logic [0:0] {HSCG_IDLE, HSCG_WAIT} hscg_seq_state_t;
  typedef struct packed {
    hscg_seq_state_t st;
    logic fin;
    logic [31:0] rd;
  } hscg_seq_t;
  hscg_seq_t s_q, s_d;

  // next state: request stays up until done is seen
  always_comb begin
    s_d = s_q;
    s_d.fin = 1'b0;
    case (s_q.st)
      HSCG_IDLE: begin
        if (start) begin
          s_d.st = HSCG_WAIT;
        end
      end
      HSCG_WAIT: begin
        if (mac.done) begin
          s_d.st = HSCG_IDLE;
          s_d.fin = 1'b1;
          s_d.rd = mac.rdata;
        end
      end
      default: s_d.st = HSCG_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_q <= '{st: HSCG_IDLE, fin: 1'b0, rd: HSCG_ZERO32};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign mac.req = (s_q.st == HSCG_WAIT);
  assign mac.rnw = rnw;
  assign mac.addr = addr;
  assign mac.wdata = wdata;
  assign busy = (s_q.st == HSCG_WAIT);
  assign finish = s_q.fin;
  assign rdata = s_q.rd;
endmodule : hscg_mac_seq

// file: hscg_mac_port.sv
// bridges the carrier to the top-level mac pins
module hscg_mac_port (
  hscg_mac_if.port mac,
  input wire logic ack,
  input wire logic [31:0] rdata_in,
  output logic req,
  output logic rnw,
  output logic [7:0] addr,
  output logic [31:0] wdata
);
  // straight mapping; registering happens in the top
  assign req = mac.req;
  assign rnw = mac.rnw;
  assign addr = mac.addr;
  assign wdata = mac.wdata;
  assign mac.done = ack;
  assign mac.rdata = rdata_in;
endmodule : hscg_mac_port

// file: hscg_top.sv
// Notes on behaviour
// - timer count reads live value, resets ones
// - run bit falling forces preload to ones
// - normal order: a1 high selects upper half
// - all-ones order register swaps half selection
// - fifo half order fixed, not this block
// - 32-bit tick counter, 25 MHz, wraps
// - first half read latches whole count
// - counter clear may take 160 ns
// - tick counter ignores power states; here it stops counting while clk_en is low
// - dropped frame counter increments per drop
// - read clears dropped counter; reset zero
// - bit 31 rising raises midpoint event
// - writing pending bit starts mac access
// - pending clears itself when access done
// - bit 30 selects read or write
// - low 8 bits address mac register
// - data register carries mac data
module hscg_top
  import hscg_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  // host half-word bus, synchronous strobes
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  // general-purpose timer state
  input wire logic [15:0] gp_timer_live,
  output logic gp_timer_run,
  output logic [15:0] gp_timer_preload,
  // receive drop pulse
  input wire logic rx_frame_dropped,
  // mac register side
  output logic mac_req,
  output logic mac_rnw,
  output logic [7:0] mac_addr,
  output logic [31:0] mac_wdata,
  input wire logic mac_ack,
  input wire logic [31:0] mac_rdata,
  // midpoint event to interrupt logic
  output logic rx_drop_midpoint
);
  typedef struct packed {
    logic [15:0] rdata;
    logic run;
    logic [15:0] preload;
    logic [31:0] word_order;
    logic [1:0] div;
    logic [31:0] tick;
    logic [31:0] tick_latch;
    logic [31:0] drop;
    logic mid;
    logic rnw;
    logic [7:0] caddr;
    logic [31:0] data;
    logic mreq;
    logic mrnw;
    logic [7:0] maddr;
    logic [31:0] mwdata;
  } hscg_state_t;
  hscg_state_t s_q, s_d;

  logic [7:0] word_addr;
  logic upper_sel;
  logic start;
  logic busy;
  logic busy_any;
  logic finish;
  logic [31:0] seq_rdata;
  logic p_req;
  logic p_rnw;
  logic [7:0] p_addr;
  logic [31:0] p_wdata;
  logic [31:0] reg_word;
  logic hi_wr;
  logic lo_wr;

  hscg_mac_if mac_bus ();

  // sequencer keeps the access open until the mac answers
  hscg_mac_seq u_seq (
    .clock(clock),
    .rstn(rstn),
    .clk_en(clk_en),
    .start(start),
    .rnw(s_q.rnw),
    .addr(s_q.caddr),
    .wdata(s_q.data),
    .busy(busy),
    .finish(finish),
    .rdata(seq_rdata),
    .mac(mac_bus.seq)
  );

  hscg_mac_port u_port (
    .mac(mac_bus.port),
    .ack(mac_ack),
    .rdata_in(mac_rdata),
    .req(p_req),
    .rnw(p_rnw),
    .addr(p_addr),
    .wdata(p_wdata)
  );

  // word address ignores the half selector bit
  assign word_addr = {host_addr[7:2], 2'b00};
  // swap remaps host halves only, never link order
  assign upper_sel = (s_q.word_order == HSCG_SWAP_KEY) ? !host_addr[HSCG_HALF_SEL_BIT]
                                                       : host_addr[HSCG_HALF_SEL_BIT];
  assign hi_wr = host_wr && upper_sel;
  assign lo_wr = host_wr && !upper_sel;

  // pending stays up through the edge that loads read data, so a
  // host that sees it clear always finds the result in place
  assign busy_any = busy || finish;
  // busy write on upper half starts an access; ignored while busy
  assign start = hi_wr && (word_addr == HSCG_OFF_MAC_CMD)
                 && host_wdata[HSCG_CMD_PENDING_BIT-16] && !busy_any;

  // read word mux; tick reads the latched sample on the second half
  always_comb begin
    reg_word = HSCG_ZERO32;
    case (word_addr)
      HSCG_OFF_GPT_CFG: reg_word = {2'b00, s_q.run, 13'h0000, s_q.preload};
      HSCG_OFF_GPT_CUR: reg_word = {HSCG_ZERO16, gp_timer_live};
      HSCG_OFF_WORD_ORDER: reg_word = s_q.word_order;
      HSCG_OFF_TICK: reg_word = s_q.tick_latch;
      HSCG_OFF_DROP: reg_word = s_q.drop;
      HSCG_OFF_MAC_CMD: reg_word = {busy_any, s_q.rnw, 22'h000000, s_q.caddr};
      HSCG_OFF_MAC_DATA: reg_word = s_q.data;
      HSCG_OFF_EVENT: reg_word = {31'h00000000, s_q.mid};
      default: reg_word = HSCG_ZERO32;
    endcase
  end

  // next-state logic for the whole bank
  always_comb begin
    s_d = s_q;
    s_d.mreq = p_req;
    s_d.mrnw = p_rnw;
    s_d.maddr = p_addr;
    s_d.mwdata = p_wdata;
    // tick divider: stalls with the rest of the bank whenever clk_en is low
    if (s_q.div == HSCG_DIV_LAST) begin
      s_d.div = 2'b00;
      s_d.tick = s_q.tick + HSCG_ONE32;
    end else begin
      s_d.div = s_q.div + 2'b01;
    end
    // first half read samples the counter
    if (host_rd) begin
      if (word_addr == HSCG_OFF_TICK && !upper_sel) begin
        s_d.tick_latch = s_q.tick;
        s_d.rdata = s_q.tick[15:0];
      end else if (word_addr == HSCG_OFF_TICK) begin
        s_d.rdata = s_q.tick_latch[31:16];
      end else begin
        s_d.rdata = upper_sel ? reg_word[31:16] : reg_word[15:0];
      end
    end
    // drop count; a drop in the clearing read cycle is kept
    if (host_rd && word_addr == HSCG_OFF_DROP) begin
      s_d.drop = rx_frame_dropped ? HSCG_ONE32 : HSCG_ZERO32;
    end else if (rx_frame_dropped) begin
      s_d.drop = s_q.drop + HSCG_ONE32;
    end
    // host clears event by writing one; new event wins
    if (lo_wr && word_addr == HSCG_OFF_EVENT && host_wdata[0]) begin
      s_d.mid = 1'b0;
    end
    // midpoint crossing from the incrementing path
    if (!s_q.drop[HSCG_DROP_MID_BIT] && s_d.drop[HSCG_DROP_MID_BIT]) begin
      s_d.mid = 1'b1;
    end
    // host writes, by half
    if (host_wr) begin
      case (word_addr)
        HSCG_OFF_GPT_CFG: begin
          if (upper_sel) begin
            s_d.run = host_wdata[HSCG_TMR_RUN_BIT-16];
            if (s_q.run && !host_wdata[HSCG_TMR_RUN_BIT-16]) begin
              s_d.preload = HSCG_TMR_ONES;
            end
          end else begin
            s_d.preload = host_wdata;
          end
        end
        HSCG_OFF_WORD_ORDER: begin
          if (upper_sel) begin
            s_d.word_order[31:16] = host_wdata;
          end else begin
            s_d.word_order[15:0] = host_wdata;
          end
        end
        HSCG_OFF_MAC_CMD: begin
          if (!busy_any) begin
            if (upper_sel) begin
              s_d.rnw = host_wdata[HSCG_CMD_RNW_BIT-16];
            end else begin
              s_d.caddr = host_wdata[7:0];
            end
          end
        end
        HSCG_OFF_MAC_DATA: begin
          if (!busy_any) begin
            if (upper_sel) begin
              s_d.data[31:16] = host_wdata;
            end else begin
              s_d.data[15:0] = host_wdata;
            end
          end
        end
        default: ;
      endcase
    end
    // read result lands in data one edge after busy drops, at the edge where pending clears
    if (finish && s_q.rnw) begin
      s_d.data = seq_rdata;
    end
  end

  // synchronous reset clears the counter at the next clock edge, whether or not clk_en is high
  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_q <= '{rdata: HSCG_ZERO16, run: 1'b0, preload: HSCG_TMR_ONES,
               word_order: HSCG_ZERO32, div: 2'b00, tick: HSCG_ZERO32,
               tick_latch: HSCG_ZERO32, drop: HSCG_ZERO32, mid: 1'b0,
               rnw: 1'b0, caddr: HSCG_ZERO8, data: HSCG_ZERO32, mreq: 1'b0,
               mrnw: 1'b0, maddr: HSCG_ZERO8, mwdata: HSCG_ZERO32};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // outputs straight from flip-flops
  assign host_rdata = s_q.rdata;
  assign gp_timer_run = s_q.run;
  assign gp_timer_preload = s_q.preload;
  assign mac_req = s_q.mreq;
  assign mac_rnw = s_q.mrnw;
  assign mac_addr = s_q.maddr;
  assign mac_wdata = s_q.mwdata;
  assign rx_drop_midpoint = s_q.mid;
endmodule : hscg_top

// file: hscg_top_monitor.sv
module hscg_top_monitor #(
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [15:0] host_wdata,
  input wire logic [15:0] host_rdata,
  input wire logic gp_timer_run,
  input wire logic [15:0] gp_timer_preload,
  input wire logic rx_frame_dropped,
  input wire logic mac_req,
  input wire logic mac_rnw,
  input wire logic [7:0] mac_addr,
  input wire logic [31:0] mac_wdata,
  input wire logic mac_ack,
  input wire logic rx_drop_midpoint
);
  timeunit 1ns;
  timeprecision 1ps;
  import hscg_pkg::*;
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rstn);
  logic go, drd;
  // start strobe, and a drop-counter read with no drop racing it
  assign go = clk_en && host_wr && host_addr == 8'ha6 && host_wdata[15];
  assign drd = clk_en && host_rd && host_addr[7:2] == HSCG_OFF_DROP[7:2] && !rx_frame_dropped;
  a_reset_state:
    assert property (disable iff (1'b0) !rstn && clk_en |=> gp_timer_preload == HSCG_TMR_ONES
      && !mac_req && !gp_timer_run && !rx_drop_midpoint) else $error("bad reset state");
  a_preload_preset:
    assert property ($fell(gp_timer_run) |-> ##[0:1] gp_timer_preload == HSCG_TMR_ONES)
    else $error("preload not preset");
  a_start_request:
    assert property (go && !mac_req |=> ##1 mac_req) else $error("no mac request");
  a_request_holds:
    assert property (mac_req && !mac_ack && !$past(mac_ack) |=> mac_req)
    else $error("request dropped early");
  a_request_ends:
    assert property (mac_req && mac_ack |=> ##1 !mac_req) else $error("request stuck");
  a_fields_hold:
    assert property (mac_req && $past(mac_req) |-> $stable({mac_rnw, mac_addr, mac_wdata}))
    else $error("fields moved in access");
  a_midpoint_cause:
    assert property (!$past(rx_frame_dropped) && !rx_frame_dropped && !rx_drop_midpoint
      |=> !rx_drop_midpoint) else $error("spurious midpoint");
  a_drop_cleared:
    assert property (drd ##1 !rx_frame_dropped ##1 drd |=> host_rdata == HSCG_ZERO16)
    else $error("drop count not cleared");
  c_mac_read: cover property (mac_req && mac_ack && mac_rnw);
  c_mac_write: cover property (mac_req && mac_ack && !mac_rnw);
  c_run_stop: cover property ($fell(gp_timer_run));
endmodule : hscg_top_monitor

// file: hscg_mac_model.sv
module hscg_mac_model (
  input wire logic clock,
  input wire logic [3:0] lag,
  input wire logic mac_req,
  input wire logic mac_rnw,
  input wire logic [7:0] mac_addr,
  input wire logic [31:0] mac_wdata,
  output logic mac_ack,
  output logic [31:0] mac_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] regs [256];
  logic [3:0] wait_q = 4'h0;
  logic done_q = 1'b0;
  initial mac_ack = 1'b0;
  initial mac_rdata = 32'h00000000;
  // one answer per request after lag cycles; data toggles when idle
  always @(posedge clock) begin
    mac_ack <= 1'b0;
    mac_rdata <= ~mac_rdata;
    if (!mac_req) begin
      wait_q <= 4'h0;
      done_q <= 1'b0;
    end else if (!done_q && wait_q == lag) begin
      mac_ack <= 1'b1;
      done_q <= 1'b1;
      if (mac_rnw) mac_rdata <= regs[mac_addr];
      else regs[mac_addr] <= mac_wdata;
    end else wait_q <= wait_q + 4'h1;
  end
endmodule : hscg_mac_model

// file: host_system_csr_group_tb.sv
module host_system_csr_group_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import hscg_pkg::*;
  logic clock = 1'b0, rstn = 1'b0, clk_en = 1'b1;
  logic host_rd = 1'b0, host_wr = 1'b0, rx_frame_dropped = 1'b0;
  logic [7:0] host_addr = 8'h00, ma = 8'h00, mac_addr;
  logic [15:0] host_wdata = 16'h0000, gp_timer_live = 16'h0000, lfsr_q = 16'he168;
  logic [15:0] host_rdata, gp_timer_preload, rd_v, pl;
  logic gp_timer_run, mac_req, mac_rnw, mac_ack, rx_drop_midpoint;
  logic [31:0] mac_wdata, mac_rdata, exp_w;
  logic [3:0] lag = 4'h0;
  int mismatches = 0, compares = 0, n;
  // 100 MHz clock
  always #5 clock = ~clock;
  hscg_top #(.ADDR_W(8)) hscg_top_i (.*);
  hscg_mac_model hscg_mac_model_i (.*);
  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction : rnd
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
    end
  endtask : chk
  // one host strobe; read data is registered, so taken one edge later
  task automatic acc(input logic wr, input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    #1 host_addr = a;
    host_wdata = d;
    host_rd = !wr;
    host_wr = wr;
    @(posedge clock);
    #1 host_rd = 1'b0;
    host_wr = 1'b0;
    rd_v = host_rdata;
  endtask : acc
  task automatic rd(input logic [7:0] a);
    acc(1'b0, a, 16'h0000);
  endtask : rd
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  // watchdog well beyond the expected run
  initial begin
    #40000;
    mismatches++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge clock);
    #1 rstn = 1'b1;
    gp_timer_live = rnd();
    rd(8'h90);
    chk(rd_v, gp_timer_live);
    rd(8'h98);
    chk(rd_v, 32'h0);
    rd(8'ha6);
    chk(rd_v, 32'h0);
    rd(8'ha8);
    chk(rd_v, 32'h0);
    chk(gp_timer_preload, 32'hffff);
    $display("reset values done");
    pl = rnd();
    acc(1'b1, 8'h8c, pl);
    acc(1'b1, 8'h8e, 16'h2000);
    chk({gp_timer_run, gp_timer_preload}, {1'b1, pl});
    acc(1'b1, 8'h8e, 16'h0000);
    #10;
    chk(gp_timer_preload, 32'hffff);
    $display("timer done");
    // all-ones swaps halves; a swapped write lands in the upper half
    acc(1'b1, 8'h98, 16'hffff);
    acc(1'b1, 8'h9a, 16'hffff);
    gp_timer_live = rnd();
    rd(8'h92);
    chk(rd_v, gp_timer_live);
    acc(1'b1, 8'h98, 16'h0000);
    rd(8'h90);
    chk(rd_v, gp_timer_live);
    rd(8'h98);
    chk(rd_v, 32'hffff);
    $display("word order done");
    rd(8'h9c);
    exp_w[15:0] = rd_v;
    repeat (38) @(posedge clock);
    rd(8'h9c);
    chk(16'(rd_v - exp_w[15:0]), 40 / HSCG_TICK_DIV);
    rd(8'h9e);
    chk(rd_v, 32'h0);
    // eight frozen edges inside a 40-edge span leave 32 that count
    rd(8'h9c);
    exp_w[15:0] = rd_v;
    repeat (15) @(posedge clock);
    #1 clk_en = 1'b0;
    repeat (8) @(posedge clock);
    #1 clk_en = 1'b1;
    repeat (15) @(posedge clock);
    rd(8'h9c);
    chk(16'(rd_v - exp_w[15:0]), 32 / HSCG_TICK_DIV);
    $display("tick counter done");
    for (int k = 0; k < 3; k++) begin
      n = rnd() % 16 + 1;
      repeat (n) begin
        @(posedge clock);
        #1 rx_frame_dropped = 1'b1;
        @(posedge clock);
        #1 rx_frame_dropped = 1'b0;
      end
      rd(8'ha0);
      chk(rd_v, n);
      rd(8'ha0);
      chk(rd_v, 32'h0);
      chk(rx_drop_midpoint, 32'h0);
    end
    // clearing an idle event flag leaves it clear
    acc(1'b1, 8'hb0, 16'h0001);
    rd(8'hb0);
    chk(rd_v, 32'h0);
    $display("drop counter done");
    for (int k = 0; k < 4; k++) begin
      lag = k[1] ? 4'h9 : 4'h0;
      if (!k[0]) begin
        ma = 8'(rnd());
        exp_w = {rnd(), rnd()};
      end
      // before a read the lower half is scrambled, so only the read restores it
      acc(1'b1, 8'ha8, k[0] ? ~exp_w[15:0] : exp_w[15:0]);
      acc(1'b1, 8'haa, exp_w[31:16]);
      acc(1'b1, 8'ha4, {8'h00, ma});
      acc(1'b1, 8'ha6, {1'b1, k[0], 14'h0000});
      acc(1'b1, 8'ha8, ~exp_w[15:0]);
      chk(mac_req, 1'b1);
      chk(mac_rnw, k[0]);
      chk(mac_addr, ma);
      chk(mac_wdata, {exp_w[31:16], k[0] ? ~exp_w[15:0] : exp_w[15:0]});
      for (int t = 0; t < 20; t++) begin
        rd(8'ha6);
        if (rd_v[15] === 1'b0) break;
      end
      chk(rd_v, {1'b0, k[0], 14'h0000});
      chk(mac_req, 1'b0);
      rd(8'ha8);
      chk(rd_v, exp_w[15:0]);
      rd(8'haa);
      chk(rd_v, exp_w[31:16]);
      rd(8'ha4);
      chk(rd_v, ma);
    end
    $display("mac access done");
    // a reset in mid-run clears both counters
    n = rnd() % 8 + 1;
    repeat (n) begin
      @(posedge clock);
      #1 rx_frame_dropped = 1'b1;
      @(posedge clock);
      #1 rx_frame_dropped = 1'b0;
    end
    @(posedge clock);
    #1 rstn = 1'b0;
    repeat (2) @(posedge clock);
    #1 rstn = 1'b1;
    // host waits out the clear time before trusting the count
    repeat (HSCG_TICK_CLEAR_CYC) @(posedge clock);
    rd(8'h9c);
    chk(rd_v, (HSCG_TICK_CLEAR_CYC + 1) / HSCG_TICK_DIV);
    rd(8'ha0);
    chk(rd_v, 32'h0);
    $display("second reset done");
    complete_run();
  end
endmodule : host_system_csr_group_tb
bind hscg_top hscg_top_monitor #(.ADDR_W(ADDR_W)) hscg_top_monitor_i (.*);
